/* File: sgoc_top.sv */
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module sgoc_top #(
	parameter int TRAV_CYC  = sgoc_pkg::TRAV_CYC_DEF,
	parameter int PULSE_CYC = sgoc_pkg::PULSE_CYC_DEF,
	parameter int TOUT_CYC  = sgoc_pkg::TOUT_CYC_DEF
) (
	// Clock, reset, enable
	input  wire logic                      i_clk_sys,
	input  wire logic                      i_rst,
	input  wire logic                      i_ce,
	// APB slave
	input  wire logic                      i_psel,
	input  wire logic                      i_penable,
	input  wire logic                      i_pwrite,
	input  wire logic [7:0]                i_paddr,
	input  wire logic [31:0]               i_pwdata,
	output logic [31:0]                    o_prdata,
	output logic                           o_pready,
	output logic                           o_pslverr,
	// Switchgear status contacts
	input  wire logic                      i_pos_open,
	input  wire logic                      i_pos_closed,
	input  wire logic                      i_cart_in,
	input  wire logic                      i_cart_out,
	input  wire logic                      i_obj_ready,
	input  wire logic                      i_sync_ok,
	// Local panel and logic commands
	input  wire logic                      i_local_open,
	input  wire logic                      i_local_close,
	input  wire logic [sgoc_pkg::NSETS-1:0] i_set_sel,
	// Outputs
	output logic [sgoc_pkg::NOUT-1:0]      o_dout,
	output sgoc_pkg::sgoc_status_t         o_status,
	output sgoc_pkg::sgoc_status_t         o_cart_status,
	output logic [2:0]                     o_active_set,
	output logic                           o_set_event,
	output logic                           o_fail_event,
	output logic                           o_latch_clear
);
	import sgoc_pkg::*;

	function automatic sgoc_status_t decode(input logic op,
		input logic cl, input logic low_long, input sgoc_status_t prev);
		if (op && cl)
			decode = SGOC_ST_BAD;
		else if (op)
			decode = SGOC_ST_OPEN;
		else if (cl)
			decode = SGOC_ST_CLOSED;
		else if (low_long)
			decode = SGOC_ST_INTER;
		else
			decode = prev;
	endfunction

	logic [31:0] ctrl_reg, ctrl_next;
	logic [31:0] set_reg, set_next;
	logic [31:0] cmd_reg, cmd_next;
	logic [31:0] prdata_reg, prdata_next;
	logic        pready_reg, pready_next;
	logic        pslverr_reg, pslverr_next;
	logic [31:0] trav_reg, trav_next;
	logic [31:0] tout_reg, tout_next;

	logic wr, rd;
	assign wr = i_psel && i_penable && i_pwrite && !pready_reg;
	assign rd = i_psel && i_penable && !i_pwrite && !pready_reg;

	logic [31:0] tlow_reg, tlow_next, clow_reg, clow_next;
	sgoc_status_t st_reg, st_next, cst_reg, cst_next;
	sgoc_fsm_t fsm_reg, fsm_next;
	logic        is_close_reg, is_close_next;
	logic [31:0] pcnt_reg, pcnt_next;
	logic [31:0] wcnt_reg, wcnt_next;
	logic [CNT_W-1:0] oreq_reg, oreq_next, creq_reg, creq_next;
	logic [CNT_W-1:0] ofail_reg, ofail_next, cfail_reg, cfail_next;
	logic [NOUT-1:0]  dout_reg, dout_next;
	logic        fail_reg, fail_next;
	logic [2:0]  aset_reg, aset_next;
	logic        sev_reg, sev_next;
	logic        lclr_reg, lclr_next;
	logic [NSETS-1:0] sel_prev_reg, sel_prev_next;

	logic obj_en, ctrl_en;
	logic req_open, req_close, close_ok;
	assign obj_en  = ctrl_reg[C_OBJ_EN];
	assign ctrl_en = ctrl_reg[C_CTRL_EN];
	// Bus open and close commands only in remote, panel only in local
	assign req_open = obj_en && (ctrl_reg[C_REMOTE] ? cmd_reg[K_OPEN]
		: i_local_open);
	assign req_close = obj_en && (ctrl_reg[C_REMOTE] ? cmd_reg[K_CLOSE]
		: i_local_close);
	assign close_ok = (!ctrl_reg[C_USE_RDY] || i_obj_ready)
		&& (!ctrl_reg[C_USE_SYN] || i_sync_ok);

	// Register slave
	always_comb begin
		ctrl_next    = ctrl_reg;
		set_next     = set_reg;
		trav_next    = trav_reg;
		tout_next    = tout_reg;
		cmd_next     = 32'h0000_0000; // Commands last one cycle
		pready_next  = 1'b0;
		pslverr_next = 1'b0;
		prdata_next  = prdata_reg;
		if (wr || rd) begin
			pready_next = 1'b1;
		end
		if (wr) begin
			case (i_paddr)
			ADDR_CTRL:   ctrl_next = i_pwdata;
			ADDR_SET:    set_next  = i_pwdata;
			ADDR_CMD:    cmd_next  = i_pwdata;
			ADDR_TIMING: trav_next = i_pwdata;
			ADDR_TOUT:   tout_next = i_pwdata;
			default:     pslverr_next = 1'b1;
			endcase
		end
		if (rd) begin
			case (i_paddr)
			ADDR_CTRL:   prdata_next = ctrl_reg;
			ADDR_SET:    prdata_next = set_reg;
			ADDR_TIMING: prdata_next = trav_reg;
			ADDR_TOUT:   prdata_next = tout_reg;
			ADDR_CMD:    prdata_next = 32'h0000_0000;
			ADDR_STAT:   prdata_next = {20'h0, fsm_reg != SGOC_IDLE,
				aset_reg, 2'h0, cst_reg, 2'h0, st_reg};
			ADDR_OREQ:   prdata_next = {16'h0, oreq_reg};
			ADDR_CREQ:   prdata_next = {16'h0, creq_reg};
			ADDR_OFAIL:  prdata_next = {16'h0, ofail_reg};
			ADDR_CFAIL:  prdata_next = {16'h0, cfail_reg};
			default: begin
				prdata_next  = 32'h0000_0000;
				pslverr_next = 1'b1;
			end
			endcase
		end
	end

	// Status decode with traverse filter
	always_comb begin
		tlow_next = (i_pos_open || i_pos_closed) ? 32'h0 :
			(tlow_reg > trav_reg ? tlow_reg : tlow_reg + 32'h1);
		clow_next = (i_cart_in || i_cart_out) ? 32'h0 :
			(clow_reg > trav_reg ? clow_reg : clow_reg + 32'h1);
		st_next  = decode(i_pos_open, i_pos_closed,
			tlow_reg > trav_reg, st_reg);
		// Cart pair only meaningful on withdrawable objects
		cst_next = (ctrl_reg[C_TYPE_LO +: 2] == SGOC_TY_WDRAW) ?
			decode(i_cart_out, i_cart_in, clow_reg > trav_reg,
			cst_reg) : SGOC_ST_INTER;
	end

	// Command sequencer and statistics
	always_comb begin
		fsm_next      = fsm_reg;
		is_close_next = is_close_reg;
		pcnt_next     = pcnt_reg;
		wcnt_next     = wcnt_reg;
		oreq_next     = oreq_reg;
		creq_next     = creq_reg;
		ofail_next    = ofail_reg;
		cfail_next    = cfail_reg;
		dout_next     = '0;
		fail_next     = 1'b0;
		case (fsm_reg)
		SGOC_IDLE: begin
			if (req_open) begin
				fsm_next      = SGOC_PULSE;
				is_close_next = 1'b0;
				pcnt_next     = 32'h0;
				wcnt_next     = 32'h0;
				oreq_next     = oreq_reg + 1'b1;
			end else if (req_close && close_ok) begin
				fsm_next      = SGOC_PULSE;
				is_close_next = 1'b1;
				pcnt_next     = 32'h0;
				wcnt_next     = 32'h0;
				creq_next     = creq_reg + 1'b1;
			end
		end
		SGOC_PULSE, SGOC_WAIT: begin
			wcnt_next = wcnt_reg + 32'h1;
			pcnt_next = pcnt_reg + 32'h1;
			if (st_reg == (is_close_reg ? SGOC_ST_CLOSED : SGOC_ST_OPEN))
				fsm_next = SGOC_IDLE;
			else if (wcnt_reg + 32'h1 >= tout_reg) begin
				fsm_next  = SGOC_IDLE;
				fail_next = 1'b1;
				if (is_close_reg)
					cfail_next = cfail_reg + 1'b1;
				else
					ofail_next = ofail_reg + 1'b1;
			end else if (fsm_reg == SGOC_PULSE &&
				pcnt_reg + 32'h1 < PULSE_CYC) begin
				dout_next[ctrl_reg[(is_close_reg ? C_CSEL_LO : C_OSEL_LO)
					+: 3]] = 1'b1;
			end else
				fsm_next = SGOC_WAIT;
		end
		default: fsm_next = SGOC_IDLE;
		endcase
		if (cmd_reg[K_CLR_STAT]) begin
			oreq_next  = '0;
			creq_next  = '0;
			ofail_next = '0;
			cfail_next = '0;
		end
	end

	// Parameter set selection
	logic [NSETS-1:0] req_vec;
	logic [2:0]       pick;
	logic             pick_v;
	always_comb begin
		sel_prev_next = i_set_sel;
		req_vec = set_reg[S_LEVELS] ? i_set_sel
			: (i_set_sel & ~sel_prev_reg);
		if (cmd_reg[K_FORCE] && set_reg[S_FORCE_EN])
			req_vec = req_vec | (8'h01 << cmd_reg[K_SET_LO +: 3]);
		if (cmd_reg[K_BUS_SET] && set_reg[S_REM_EN])
			req_vec = req_vec | (8'h01 << cmd_reg[K_SET_LO +: 3]);
		req_vec = req_vec & set_reg[S_USED_LO +: NSETS];
		pick   = 3'h0;
		pick_v = 1'b0;
		for (int k = NSETS - 1; k >= 0; k--) begin
			if (req_vec[k]) begin
				pick   = k[2:0];
				pick_v = 1'b1;
			end
		end
		aset_next = aset_reg;
		sev_next  = 1'b0;
		if (ctrl_en && pick_v && pick != aset_reg) begin
			aset_next = pick;
			sev_next  = set_reg[S_MASK_LO + pick];
		end
		lclr_next = cmd_reg[K_LATCH_RST];
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			ctrl_reg     <= CTRL_RST;
			set_reg      <= SET_RST;
			cmd_reg      <= 32'h0000_0000;
			trav_reg     <= TRAV_CYC;
			tout_reg     <= TOUT_CYC;
			prdata_reg   <= 32'h0000_0000;
			pready_reg   <= 1'b0;
			pslverr_reg  <= 1'b0;
			tlow_reg     <= 32'h0;
			clow_reg     <= 32'h0;
			st_reg       <= SGOC_ST_INTER;
			cst_reg      <= SGOC_ST_INTER;
			fsm_reg      <= SGOC_IDLE;
			is_close_reg <= 1'b0;
			pcnt_reg     <= 32'h0;
			wcnt_reg     <= 32'h0;
			oreq_reg     <= '0;
			creq_reg     <= '0;
			ofail_reg    <= '0;
			cfail_reg    <= '0;
			dout_reg     <= '0;
			fail_reg     <= 1'b0;
			aset_reg     <= 3'h0;
			sev_reg      <= 1'b0;
			lclr_reg     <= 1'b0;
			sel_prev_reg <= '0;
		end else if (i_ce) begin
			ctrl_reg     <= ctrl_next;
			set_reg      <= set_next;
			cmd_reg      <= cmd_next;
			trav_reg     <= trav_next;
			tout_reg     <= tout_next;
			prdata_reg   <= prdata_next;
			pready_reg   <= pready_next;
			pslverr_reg  <= pslverr_next;
			tlow_reg     <= tlow_next;
			clow_reg     <= clow_next;
			st_reg       <= st_next;
			cst_reg      <= cst_next;
			fsm_reg      <= fsm_next;
			is_close_reg <= is_close_next;
			pcnt_reg     <= pcnt_next;
			wcnt_reg     <= wcnt_next;
			oreq_reg     <= oreq_next;
			creq_reg     <= creq_next;
			ofail_reg    <= ofail_next;
			cfail_reg    <= cfail_next;
			dout_reg     <= dout_next;
			fail_reg     <= fail_next;
			aset_reg     <= aset_next;
			sev_reg      <= sev_next;
			lclr_reg     <= lclr_next;
			sel_prev_reg <= sel_prev_next;
		end
	end

	assign o_prdata      = prdata_reg;
	assign o_pready      = pready_reg;
	assign o_pslverr     = pslverr_reg;
	assign o_dout        = dout_reg;
	assign o_status      = st_reg;
	assign o_cart_status = cst_reg;
	assign o_active_set  = aset_reg;
	assign o_set_event   = sev_reg;
	assign o_fail_event  = fail_reg;
	assign o_latch_clear = lclr_reg;
endmodule
`default_nettype wire

/* File: sgoc_pkg.sv */
// Functional notes
// - Both position inputs low reports intermittent.
// - Both position inputs of object or cart high reports bad.
// - Access defaults local; local ignores bus open/close, remote ignores local commands.
// - Enabled ready or synchronism check blocks close without its permission.
// - Separate open and close request counters count accepted requests.
// - Failure counters count requests ending without matching status change.
// - Clear statistics zeroes all request and failure counters.
// - Withdrawable object takes cart inserted and withdrawn inputs.
// - Open and close commands drive a selected digital output each.
// - Object type selects one of four kinds; breaker by default.
// - Object and control functions disabled after reset until enabled.
// - Eight parameter sets held; active set number reported.
// - Forced set change only acts while force enable is set.
// - Lowest-numbered active select request wins.
// - Per-set usage enable; only set zero enabled after reset.
// - Bus set change requests accepted only with remote change enabled.
// - Set select inputs taken as pulses only or pulses and levels.
// - Set change events masked after reset; only masked-in events recorded.
// - Latch reset clears latched signals and returns itself to idle.
// - Command output held at most max pulse, cut when status reaches the commanded position.
// - No status change within timeout aborts request and logs failure.
// - Intermittent reported only after both low beyond traverse time.
package sgoc_pkg;
	localparam int CNT_W = 16;
	localparam int NSETS = 8;
	localparam int NOUT  = 8;
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_TIMING = 8'h04;
	localparam logic [7:0] ADDR_SET    = 8'h08;
	localparam logic [7:0] ADDR_CMD    = 8'h0C;
	localparam logic [7:0] ADDR_STAT   = 8'h10;
	localparam logic [7:0] ADDR_OREQ   = 8'h14;
	localparam logic [7:0] ADDR_CREQ   = 8'h18;
	localparam logic [7:0] ADDR_OFAIL  = 8'h1C;
	localparam logic [7:0] ADDR_CFAIL  = 8'h20;
	localparam logic [7:0] ADDR_TOUT   = 8'h24;
	// Control bits
	localparam int C_OBJ_EN   = 0;
	localparam int C_REMOTE   = 1;
	localparam int C_USE_RDY  = 2;
	localparam int C_USE_SYN  = 3;
	localparam int C_TYPE_LO  = 4;
	localparam int C_OSEL_LO  = 8;
	localparam int C_CSEL_LO  = 12;
	localparam int C_CTRL_EN  = 16;
	// Set register fields
	localparam int S_USED_LO  = 0;
	localparam int S_MASK_LO  = 8;
	localparam int S_FORCE_EN = 16;
	localparam int S_REM_EN   = 17;
	localparam int S_LEVELS   = 18;
	// Command register bits (self-clearing)
	localparam int K_OPEN     = 0;
	localparam int K_CLOSE    = 1;
	localparam int K_CLR_STAT = 2;
	localparam int K_LATCH_RST= 3;
	localparam int K_FORCE    = 4;
	localparam int K_BUS_SET  = 5;
	localparam int K_SET_LO   = 8;
	// Timing defaults in microseconds
	localparam int TRAV_US_DEF  = 200;
	localparam int PULSE_US_DEF = 200;
	localparam int TOUT_US_DEF  = 1000;
	localparam int CLK_MHZ      = 200;
	localparam int TRAV_CYC_DEF  = TRAV_US_DEF * CLK_MHZ;
	localparam int PULSE_CYC_DEF = PULSE_US_DEF * CLK_MHZ;
	localparam int TOUT_CYC_DEF  = TOUT_US_DEF * CLK_MHZ;
	localparam logic [31:0] CTRL_RST = 32'h0000_0020;
	localparam logic [31:0] SET_RST  = 32'h0000_0001;
	typedef enum logic [1:0] {
		SGOC_ST_INTER  = 2'h0,
		SGOC_ST_OPEN   = 2'h1,
		SGOC_ST_CLOSED = 2'h2,
		SGOC_ST_BAD    = 2'h3
	} sgoc_status_t;
	typedef enum logic [1:0] {
		SGOC_TY_GND   = 2'h0,
		SGOC_TY_MOTOR = 2'h1,
		SGOC_TY_BRK   = 2'h2,
		SGOC_TY_WDRAW = 2'h3
	} sgoc_type_t;
	typedef enum logic [1:0] {
		SGOC_IDLE   = 2'b00,
		SGOC_PULSE  = 2'b01,
		SGOC_WAIT   = 2'b11
	} sgoc_fsm_t;
endpackage

/* File: sgoc_chk_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module sgoc_chk
	import sgoc_pkg::*;
#(
	parameter int PULSE_CYC = sgoc_pkg::PULSE_CYC_DEF
) (
	// Watched design ports
	input wire logic                      i_clk_sys,
	input wire logic                      i_rst,
	input wire logic                      i_pos_open,
	input wire logic                      i_pos_closed,
	input wire logic [sgoc_pkg::NOUT-1:0] o_dout,
	input wire sgoc_pkg::sgoc_status_t    o_status,
	input wire logic                      o_fail_event,
	input wire logic                      o_latch_clear
);
	logic [31:0] run_reg;
	logic [31:0] run_next;
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);
	// One cycle of slack for the registered cut-off
	always_comb begin
		run_next = (o_dout != '0) ? run_reg + 32'h1 : 32'h0;
	end
	always_ff @(posedge i_clk_sys) begin
		run_reg <= i_rst ? 32'h0 : run_next;
	end
	AST_BAD: assert property (
		i_pos_open && i_pos_closed |=> o_status == SGOC_ST_BAD)
		else $error("both contacts high not reported bad");
	AST_OPEN: assert property (
		i_pos_open && !i_pos_closed |=> o_status == SGOC_ST_OPEN)
		else $error("open contact alone not reported open");
	AST_INTER_WAIT: assert property (
		$fell(i_pos_open) && !i_pos_closed |=> (o_status != SGOC_ST_INTER)[*2])
		else $error("intermittent reported before traverse time");
	AST_ONEHOT: assert property ($onehot0(o_dout))
		else $error("more than one command output high");
	AST_PULSE_MAX: assert property (run_reg <= PULSE_CYC + 1)
		else $error("command pulse longer than maximum");
	AST_CUT: assert property (
		o_dout != '0 && $changed(o_status) &&
		o_status inside {SGOC_ST_OPEN, SGOC_ST_CLOSED} |-> ##[0:2] o_dout == '0)
		else $error("command pulse not cut on status change");
	AST_FAIL_IDLE: assert property (o_fail_event |-> o_dout == '0)
		else $error("failure reported while command still driven");
	AST_LATCH_PULSE: assert property (
		o_latch_clear |=> !o_latch_clear)
		else $error("latch clear did not return to idle");
	CV_FAIL: cover property (o_fail_event);
	CV_BAD: cover property (o_status == SGOC_ST_BAD);
	CV_CUT: cover property (o_dout != '0 ##1 o_dout == '0);
endmodule
bind sgoc_top sgoc_chk #(.PULSE_CYC(PULSE_CYC)) u_chk (
	.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pos_open(i_pos_open),
	.i_pos_closed(i_pos_closed), .o_dout(o_dout), .o_status(o_status),
	.o_fail_event(o_fail_event), .o_latch_clear(o_latch_clear)
);
`default_nettype wire

/* File: sgoc_gear_mdl.sv */
`timescale 1ns/10ps
`default_nettype none
module sgoc_gear_mdl (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// Command coils, fault mode: 0 works, 1 stuck, 2 both contacts made
	input  wire logic       i_open_cmd,
	input  wire logic       i_close_cmd,
	input  wire logic [1:0] i_fault,
	// Position contacts
	output logic            o_pos_open,
	output logic            o_pos_closed
);
	logic       closed_reg;
	logic [1:0] trav_reg;
	logic       moving;
	// A stuck mechanism never leaves its end position
	assign moving = i_fault == 2'h0 && (closed_reg ? i_open_cmd : i_close_cmd);
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			closed_reg <= 1'b0;
			trav_reg <= 2'h0;
		end else begin
			trav_reg <= moving ? trav_reg + 2'h1 : 2'h0;
			if (moving && trav_reg == 2'h3) closed_reg <= !closed_reg;
		end
	end
	// Both contacts open for three cycles in transit
	assign o_pos_open = i_fault == 2'h2 || (!closed_reg && trav_reg == 2'h0);
	assign o_pos_closed = i_fault == 2'h2 || (closed_reg && trav_reg == 2'h0);
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
	import sgoc_pkg::*;
	logic         clk, rst, psel, penable, pwrite, pready, pslverr, last_err;
	logic [7:0]   paddr, set_sel, dout;
	logic [31:0]  pwdata, prdata, rdv;
	logic         pos_open, pos_closed, cart_in, cart_out, obj_ready, sync_ok;
	logic         loc_open, loc_close, set_ev, fail_ev, latch_clr, ce;
	logic [2:0]   act_set;
	logic [1:0]   fault;
	sgoc_status_t status, cart_st;
	int           num_errors, n_compared;
	sgoc_top #(.TRAV_CYC(4), .PULSE_CYC(8), .TOUT_CYC(20)) dut (
		.i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_pos_open(pos_open), .i_pos_closed(pos_closed),
		.i_cart_in(cart_in), .i_cart_out(cart_out), .i_obj_ready(obj_ready),
		.i_sync_ok(sync_ok), .i_local_open(loc_open), .i_local_close(loc_close),
		.i_set_sel(set_sel), .o_dout(dout), .o_status(status),
		.o_cart_status(cart_st), .o_active_set(act_set), .o_set_event(set_ev),
		.o_fail_event(fail_ev), .o_latch_clear(latch_clr));
	sgoc_gear_mdl gear (.i_clk(clk), .i_rst(rst), .i_open_cmd(dout[0]),
		.i_close_cmd(dout[1]), .i_fault(fault), .o_pos_open(pos_open),
		.o_pos_closed(pos_closed));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		// Idle edge so a back-to-back call never re-drives psel in one step
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rdv = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk({31'h0, pready}, 32'h1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hFFFF_FFFF);
		apb(1'b0, a, 32'h0);
		chk(rdv & m, e);
	endtask
	// 0 set event, 1 failure, 2 latch clear, 3 any command output
	task automatic wait_hi(input int k);
		logic hit;
		hit = 1'b0;
		for (int n = 0; n < 60 && !hit; n++) begin
			@(posedge clk);
			hit = k == 0 ? set_ev : k == 1 ? fail_ev : k == 2 ? latch_clr
				: dout !== 8'h00;
		end
		chk({31'h0, hit}, 32'h1);
	endtask
	task automatic wait_st(input sgoc_status_t s);
		for (int n = 0; n < 60 && status !== s; n++) @(posedge clk);
		chk({30'h0, status}, {30'h0, s});
	endtask
	// Any command output or set event within the span counts
	task automatic idle_out(input int c);
		logic [31:0] seen;
		seen = 32'h0;
		repeat (c) begin
			@(posedge clk);
			seen = seen | {23'h0, set_ev, dout};
		end
		chk(seen, 32'h0);
	endtask
	task automatic set_is(input logic [2:0] s);
		repeat (4) @(posedge clk);
		chk({29'h0, act_set}, {29'h0, s});
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#100000;
		num_errors++;
		wrap_up();
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, set_sel} <= '0;
		{cart_in, cart_out, obj_ready, loc_open, loc_close, fault} <= '0;
		rst <= 1'b1;
		sync_ok <= 1'b1;
		ce <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(ADDR_CTRL, CTRL_RST);
		rd(ADDR_SET, SET_RST);
		rd(8'h40, 32'h0);
		chk({31'h0, last_err}, 32'h1);
		rd(ADDR_STAT, 32'h1, 32'h3);
		chk({29'h0, act_set}, 32'h0);
		wr(ADDR_CMD, 32'h2);
		idle_out(10);
		$display("reset state done");
		wr(ADDR_TIMING, 32'h4);
		wr(ADDR_TOUT, 32'h14);
		wr(ADDR_CTRL, 32'h0001_1023);
		wr(ADDR_CMD, 32'h2);
		wait_hi(3);
		chk({24'h0, dout}, 32'h2);
		wait_st(SGOC_ST_CLOSED);
		rd(ADDR_CREQ, 32'h1);
		loc_open <= 1'b1;
		idle_out(10);
		loc_open <= 1'b0;
		wr(ADDR_CMD, 32'h1);
		wait_hi(3);
		chk({24'h0, dout}, 32'h1);
		wait_st(SGOC_ST_OPEN);
		rd(ADDR_OREQ, 32'h1);
		rd(ADDR_OFAIL, 32'h0);
		$display("remote control done");
		fault <= 2'h1;
		wr(ADDR_CMD, 32'h2);
		wait_hi(1);
		rd(ADDR_CFAIL, 32'h1);
		fault <= 2'h0;
		wr(ADDR_CTRL, 32'h0001_1027);
		wr(ADDR_CMD, 32'h2);
		idle_out(10);
		rd(ADDR_CREQ, 32'h2);
		$display("failure and permission done");
		obj_ready <= 1'b1;
		wr(ADDR_CTRL, 32'h0001_1025);
		wr(ADDR_CMD, 32'h2);
		idle_out(10);
		loc_close <= 1'b1;
		wait_hi(3);
		chk({24'h0, dout}, 32'h2);
		loc_close <= 1'b0;
		wait_st(SGOC_ST_CLOSED);
		rd(ADDR_CREQ, 32'h3);
		wr(ADDR_CMD, 32'h4);
		for (int i = 0; i < 4; i++) rd(ADDR_OREQ + 8'(4 * i), 32'h0);
		$display("local control done");
		fault <= 2'h2;
		wait_st(SGOC_ST_BAD);
		fault <= 2'h0;
		wr(ADDR_CTRL, 32'h0001_1035);
		{cart_in, cart_out} <= 2'b11;
		repeat (3) @(posedge clk);
		chk({30'h0, cart_st}, {30'h0, SGOC_ST_BAD});
		cart_out <= 1'b0;
		repeat (3) @(posedge clk);
		chk({30'h0, cart_st}, {30'h0, SGOC_ST_CLOSED});
		// Short traverse so the three-cycle transit shows as intermittent
		wr(ADDR_TIMING, 32'h1);
		loc_open <= 1'b1;
		wait_st(SGOC_ST_INTER);
		loc_open <= 1'b0;
		wait_st(SGOC_ST_OPEN);
		$display("status decode done");
		wr(ADDR_SET, 32'h0004_FFFF);
		set_sel <= 8'h28;
		wait_hi(0);
		set_is(3'h3);
		set_sel <= 8'h00;
		wr(ADDR_SET, 32'h0000_FFFF);
		set_sel <= 8'h80;
		@(posedge clk);
		set_sel <= 8'h00;
		set_is(3'h7);
		wr(ADDR_CMD, 32'h0000_0510);
		set_is(3'h7);
		wr(ADDR_SET, 32'h0001_FFFF);
		wr(ADDR_CMD, 32'h0000_0510);
		set_is(3'h5);
		wr(ADDR_CMD, 32'h0000_0220);
		set_is(3'h5);
		rd(ADDR_STAT, 32'h0000_0500, 32'h0000_0F00);
		wr(ADDR_SET, 32'h0002_FFFF);
		wr(ADDR_CMD, 32'h0000_0220);
		set_is(3'h2);
		wr(ADDR_SET, 32'h0000_00FF);
		set_sel <= 8'h02;
		@(posedge clk);
		set_sel <= 8'h00;
		idle_out(4);
		set_is(3'h1);
		// Frozen edge detector must still catch the rise once enabled
		ce <= 1'b0;
		set_sel <= 8'h01;
		repeat (3) @(posedge clk);
		chk({29'h0, act_set}, 32'h1);
		ce <= 1'b1;
		set_is(3'h0);
		wr(ADDR_CMD, 32'h8);
		wait_hi(2);
		$display("parameter sets done");
		wrap_up();
	end
endmodule
`default_nettype wire
